// ### rtl/fsbp_map.svh
`ifndef FSBP_MAP_SVH
`define FSBP_MAP_SVH

`define FSBP_OP_WRSR      8'h01
`define FSBP_OP_PROG      8'h02
`define FSBP_OP_RDSR      8'h05
`define FSBP_OP_WRDI      8'h04
`define FSBP_OP_WREN      8'h06
`define FSBP_OP_CLFSR     8'h50
`define FSBP_OP_RDFSR     8'h70
`define FSBP_OP_BULK      8'hc7
`define FSBP_OP_SECT      8'hd8

`define FSBP_SR_SRWD      7
`define FSBP_SR_BP3       6
`define FSBP_SR_TB        5
`define FSBP_SR_BP_HI     4
`define FSBP_SR_BP_LO     2
`define FSBP_SR_WEL       1
`define FSBP_SR_WIP       0

`define FSBP_RST_SRWD     1'b1
`define FSBP_RST_TB       1'b1
`define FSBP_RST_BP       4'h0

`define FSBP_SECT_HI      25
`define FSBP_SECT_LO      16
`define FSBP_LVL_MAX      4'ha

`define FSBP_BITS_CMD     6'h08
`define FSBP_BITS_WRSR    6'h10
`define FSBP_BITS_SECT    6'h28
`define FSBP_BITS_PROG    6'h30

`define FSBP_CLK_NS       100
`define FSBP_T_WRSR_NS    2000
`define FSBP_T_PROG_NS    5000
`define FSBP_T_SECT_NS    50000
`define FSBP_T_BULK_NS    1000000

`endif

// ### rtl/fsbp_pkg.sv
package fsbp_pkg;

    typedef enum logic [0:0] {
        FSBP_IDLE,
        FSBP_BUSY
    } fsbp_state_e;

    typedef struct packed {
        logic [7:0]  cmd;
        logic [31:0] addr;
        logic [7:0]  data;
        logic [5:0]  nbits;
    } fsbp_frame_s;

    typedef struct packed {
        logic        valid;
        logic        erase;
        logic        bulk;
        logic [25:0] addr;
        logic [7:0]  data;
    } fsbp_arr_op_s;

    typedef logic [23:0] fsbp_count_t;

endpackage

// ### rtl/fsbp_prot.sv
`include "fsbp_map.svh"

module fsbp_prot
    import fsbp_pkg::*;
(
    input  wire logic [3:0] level,
    input  wire logic       bottom,
    input  wire logic [9:0] sector,
    output logic            hit
);
    logic [10:0] span;
    logic [10:0] sect_w;

    always_comb begin
        span   = 11'h001 << (level - 4'h1);
        sect_w = {1'b0, sector};
        if (level == 4'h0) begin
            hit = 1'b0;
        end else if (level > `FSBP_LVL_MAX) begin
            hit = 1'b1;
        end else if (bottom) begin
            hit = sect_w < span;
        end else begin
            hit = sect_w >= (11'h400 - span);
        end
    end

endmodule

// ### rtl/fsbp_top.sv
`include "fsbp_map.svh"

module fsbp_top
    import fsbp_pkg::*;
#(
    parameter fsbp_count_t WRSR_CYC = fsbp_count_t'((`FSBP_T_WRSR_NS + `FSBP_CLK_NS - 1)
                                                    / `FSBP_CLK_NS),
    parameter fsbp_count_t PROG_CYC = fsbp_count_t'((`FSBP_T_PROG_NS + `FSBP_CLK_NS - 1)
                                                    / `FSBP_CLK_NS),
    parameter fsbp_count_t SECT_CYC = fsbp_count_t'((`FSBP_T_SECT_NS + `FSBP_CLK_NS - 1)
                                                    / `FSBP_CLK_NS),
    parameter fsbp_count_t BULK_CYC = fsbp_count_t'((`FSBP_T_BULK_NS + `FSBP_CLK_NS - 1)
                                                    / `FSBP_CLK_NS)
)
(
    input  wire logic   SYS_CLK,
    input  wire logic   RST_N,
    input  wire logic   LINK_CLK,
    input  wire logic   CS_N,
    input  wire logic   DI,
    input  wire logic   WP_N,
    output logic        DO,
    output logic        DO_OE_N,
    output logic [7:0]  STATUS,
    output fsbp_arr_op_s ARR_OP
);
    // Link domain: runs only while the frame is selected.
    logic [5:0]   cnt_q;
    logic [7:0]   sh_q;
    fsbp_frame_s  frm_q;
    logic [15:0]  st_s1_q;
    logic [15:0]  st_s2_q;
    logic [7:0]   out_q;
    logic [7:0]   out_sel;
    logic         rd_cmd;
    logic         do_q;
    logic         oe_n_q;

    // System domain.
    logic         cs_s1_q;
    logic         cs_s2_q;
    logic         cs_s3_q;
    logic         wp_s1_q;
    logic         wp_s2_q;
    logic         frame_end;
    fsbp_state_e  state_q;
    fsbp_count_t  timer_q;
    logic         srwd_q;
    logic         tb_q;
    logic [3:0]   bp_q;
    logic         wel_q;
    logic         prot_err_q;
    logic         prog_err_q;
    logic         erase_err_q;
    logic [15:0]  snap_q;
    logic [7:0]   status_d;
    logic [7:0]   flag_d;
    logic         sect_hit;
    logic         busy;
    logic         wr_ok;
    logic [7:0]   cmd;

    // Frame capture on the rising serial clock; CS_N high clears only the bit counter,
    // so captured fields stay stable for the system side once the clock has stopped.
    always_ff @(posedge LINK_CLK or posedge CS_N) begin
        if (CS_N) begin
            cnt_q <= 6'h00;
        end else if (cnt_q != 6'h3f) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        sh_q      <= {sh_q[6:0], DI};
        frm_q.nbits <= (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;
        if (cnt_q == 6'h07) begin
            frm_q.cmd <= {sh_q[6:0], DI};
        end
        if (cnt_q >= 6'h08 && cnt_q < 6'h28) begin
            frm_q.addr <= {frm_q.addr[30:0], DI};
        end
        if (cnt_q >= 6'h28 && cnt_q < 6'h30) begin
            frm_q.data <= {frm_q.data[6:0], DI};
        end
    end

    // Status snapshot crosses by two flops; it only changes between frames.
    always_ff @(posedge LINK_CLK or posedge CS_N) begin
        if (CS_N) begin
            st_s1_q <= 16'h0000;
            st_s2_q <= 16'h0000;
        end else begin
            st_s1_q <= snap_q;
            st_s2_q <= st_s1_q;
        end
    end

    always_comb begin
        rd_cmd  = (frm_q.cmd == `FSBP_OP_RDSR) || (frm_q.cmd == `FSBP_OP_RDFSR);
        out_sel = (frm_q.cmd == `FSBP_OP_RDFSR) ? st_s2_q[15:8] : st_s2_q[7:0];
    end

    // Read data leaves on the falling edge, most significant bit first, and repeats.
    always_ff @(negedge LINK_CLK or posedge CS_N) begin
        if (CS_N) begin
            do_q   <= 1'b0;
            oe_n_q <= 1'b1;
            out_q  <= 8'h00;
        end else if (cnt_q == `FSBP_BITS_CMD && rd_cmd) begin
            do_q   <= out_sel[7];
            oe_n_q <= 1'b0;
            out_q  <= {out_sel[6:0], out_sel[7]};
        end else if (cnt_q > `FSBP_BITS_CMD && rd_cmd) begin
            do_q   <= out_q[7];
            oe_n_q <= 1'b0;
            out_q  <= {out_q[6:0], out_q[7]};
        end else begin
            oe_n_q <= 1'b1;
        end
    end

    assign DO      = do_q;
    assign DO_OE_N = oe_n_q;

    always_ff @(posedge SYS_CLK) begin
        cs_s1_q <= CS_N;
        cs_s2_q <= cs_s1_q;
        cs_s3_q <= cs_s2_q;
        wp_s1_q <= WP_N;
        wp_s2_q <= wp_s1_q;
    end

    assign frame_end = cs_s2_q & ~cs_s3_q;
    assign busy      = (state_q == FSBP_BUSY);
    assign cmd       = frm_q.cmd;
    // Writes to the status are locked while bit 7 is set and the pin is held low.
    assign wr_ok     = !(srwd_q && !wp_s2_q);

    fsbp_prot u_prot (
        .level  (bp_q),
        .bottom (tb_q),
        .sector (frm_q.addr[`FSBP_SECT_HI:`FSBP_SECT_LO]),
        .hit    (sect_hit)
    );

    always_comb begin
        status_d = {srwd_q, bp_q[3], tb_q, bp_q[2:0], wel_q, busy};
        flag_d   = {~busy, 1'b0, erase_err_q, prog_err_q, 1'b0, 1'b0, prot_err_q,
                    1'b1};
    end

    // The snapshot freezes during a frame so the link never sees it change mid-read.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            snap_q <= 16'h0000;
            STATUS <= 8'h00;
        end else begin
            STATUS <= status_d;
            if (cs_s2_q) begin
                snap_q <= {flag_d, status_d};
            end
        end
    end

    // Nonvolatile bits: reset loads the factory values, standing for first power-up.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            srwd_q <= `FSBP_RST_SRWD;
            tb_q   <= `FSBP_RST_TB;
            bp_q   <= `FSBP_RST_BP;
        end else if (frame_end && !busy && cmd == `FSBP_OP_WRSR && wel_q && wr_ok
                     && frm_q.nbits == `FSBP_BITS_WRSR) begin
            srwd_q <= frm_q.addr[`FSBP_SR_SRWD];
            tb_q   <= frm_q.addr[`FSBP_SR_TB];
            bp_q   <= {frm_q.addr[`FSBP_SR_BP3], frm_q.addr[`FSBP_SR_BP_HI:`FSBP_SR_BP_LO]};
        end
    end

    // Write-enable latch: any accepted write, or one refused for lock or protection, ends with it cleared.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            wel_q <= 1'b0;
        end else if (busy) begin
            if (timer_q == fsbp_count_t'(1)) begin
                wel_q <= 1'b0;
            end
        end else if (frame_end) begin
            if (cmd == `FSBP_OP_WREN && frm_q.nbits == `FSBP_BITS_CMD) begin
                wel_q <= 1'b1;
            end else if (cmd == `FSBP_OP_WRDI && frm_q.nbits == `FSBP_BITS_CMD) begin
                wel_q <= 1'b0;
            end else if (cmd == `FSBP_OP_WRSR && !wr_ok) begin
                wel_q <= 1'b0;
            end else if ((cmd == `FSBP_OP_PROG || cmd == `FSBP_OP_SECT) && sect_hit) begin
                wel_q <= 1'b0;
            end else if (cmd == `FSBP_OP_BULK && bp_q != 4'h0) begin
                wel_q <= 1'b0;
            end
        end
    end

    // Cycle sequencer and array operation issue.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_q <= FSBP_IDLE;
            timer_q <= '0;
            ARR_OP  <= '0;
        end else begin
            ARR_OP.valid <= 1'b0;
            case (state_q)
                FSBP_IDLE: begin
                    if (frame_end && wel_q) begin
                        if (cmd == `FSBP_OP_WRSR && wr_ok
                            && frm_q.nbits == `FSBP_BITS_WRSR) begin
                            state_q <= FSBP_BUSY;
                            timer_q <= WRSR_CYC;
                        end else if (cmd == `FSBP_OP_PROG && !sect_hit
                                     && frm_q.nbits >= `FSBP_BITS_PROG) begin
                            state_q <= FSBP_BUSY;
                            timer_q <= PROG_CYC;
                            ARR_OP  <= '{1'b1, 1'b0, 1'b0, frm_q.addr[25:0], frm_q.data};
                        end else if (cmd == `FSBP_OP_SECT && !sect_hit
                                     && frm_q.nbits == `FSBP_BITS_SECT) begin
                            state_q <= FSBP_BUSY;
                            timer_q <= SECT_CYC;
                            ARR_OP  <= '{1'b1, 1'b1, 1'b0, frm_q.addr[25:0], 8'hff};
                        end else if (cmd == `FSBP_OP_BULK && bp_q == 4'h0
                                     && frm_q.nbits == `FSBP_BITS_CMD) begin
                            state_q <= FSBP_BUSY;
                            timer_q <= BULK_CYC;
                            ARR_OP  <= '{1'b1, 1'b1, 1'b1, 26'h0000000, 8'hff};
                        end
                    end
                end
                FSBP_BUSY: begin
                    timer_q <= timer_q - fsbp_count_t'(1);
                    if (timer_q == fsbp_count_t'(1)) begin
                        state_q <= FSBP_IDLE;
                    end
                end
                default: begin
                    state_q <= FSBP_IDLE;
                end
            endcase
        end
    end

    // Error flags; a program or erase refused for protection sets the protection flag and the program or erase flag, the clear command drops all three.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            prot_err_q  <= 1'b0;
            prog_err_q  <= 1'b0;
            erase_err_q <= 1'b0;
        end else if (frame_end && !busy && wel_q
                     && ((cmd == `FSBP_OP_PROG || cmd == `FSBP_OP_SECT) && sect_hit
                         || cmd == `FSBP_OP_BULK && bp_q != 4'h0)) begin
            prot_err_q  <= 1'b1;
            prog_err_q  <= prog_err_q | (cmd == `FSBP_OP_PROG);
            erase_err_q <= erase_err_q | (cmd != `FSBP_OP_PROG);
        end else if (frame_end && !busy && cmd == `FSBP_OP_CLFSR) begin
            prot_err_q  <= 1'b0;
            prog_err_q  <= 1'b0;
            erase_err_q <= 1'b0;
        end
    end

endmodule

// ### testbench/fsbp_ref_pkg.sv
package fsbp_ref_pkg;

    // Expected protection of one 64KB sector for a level and anchor.
    function automatic logic prot(input logic [3:0] lv,
                                  input logic       bot,
                                  input logic [9:0] sec);
        logic [10:0] n;
        n = 11'h1 << (lv - 4'h1);
        if (lv == 4'h0) return 1'b0;
        if (lv > 4'ha) return 1'b1;
        return bot ? ({1'b0, sec} < n) : ({1'b0, sec} >= 11'h400 - n);
    endfunction

endpackage

// ### testbench/fsbp_sva.sv
module fsbp_sva
    import fsbp_pkg::*;
    import fsbp_ref_pkg::*;
#(
    parameter fsbp_count_t WRSR_CYC = 24'h3,
    parameter fsbp_count_t PROG_CYC = 24'h4,
    parameter fsbp_count_t SECT_CYC = 24'h5,
    parameter fsbp_count_t BULK_CYC = 24'h6
)
(
    input wire logic         SYS_CLK,
    input wire logic         RST_N,
    input wire logic         CS_N,
    input wire logic         WP_N,
    input wire logic         DO_OE_N,
    input wire logic [7:0]   STATUS,
    input wire fsbp_arr_op_s ARR_OP
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0]  wp_lo_q;
    fsbp_count_t busy_q;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // The pin is synchronised, so the lock is judged only once it has settled.
    always_ff @(posedge SYS_CLK) begin
        wp_lo_q <= (!RST_N || WP_N) ? 3'h0 : wp_lo_q + {2'h0, wp_lo_q != 3'h7};
    end
    always_ff @(posedge SYS_CLK) begin
        busy_q <= (!RST_N || !STATUS[0]) ? 24'h0 : busy_q + 24'h1;
    end
    property p_op_pulse;
        ARR_OP.valid |=> !ARR_OP.valid;
    endproperty
    a_op_pulse: assert property (p_op_pulse) else $error("op pulse too long");
    property p_op_busy;
        ARR_OP.valid |-> ##[0:3] STATUS[0];
    endproperty
    a_op_busy: assert property (p_op_busy) else $error("op without busy");
    property p_bulk;
        ARR_OP.valid && ARR_OP.bulk |-> {STATUS[6], STATUS[4:2]} == 4'h0;
    endproperty
    a_bulk: assert property (p_bulk) else $error("bulk erase while protected");
    property p_prot;
        ARR_OP.valid && !ARR_OP.bulk |->
            !prot({STATUS[6], STATUS[4:2]}, STATUS[5], ARR_OP.addr[25:16]);
    endproperty
    a_prot: assert property (p_prot) else $error("op to protected sector");
    property p_wp_lock;
        STATUS[7] && wp_lo_q == 3'h7 |=> STATUS[7:2] == $past(STATUS[7:2]);
    endproperty
    a_wp_lock: assert property (p_wp_lock) else $error("locked status changed");
    property p_wel_end;
        $fell(STATUS[0]) |-> ##[0:1] !STATUS[1];
    endproperty
    a_wel_end: assert property (p_wel_end) else $error("latch kept after cycle");
    property p_busy_len;
        $fell(STATUS[0]) |-> busy_q >= WRSR_CYC;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too short");
    property p_oe_idle;
        CS_N && $past(CS_N) |-> DO_OE_N;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output driven unselected");
endmodule

bind fsbp_top fsbp_sva #(.WRSR_CYC(WRSR_CYC), .PROG_CYC(PROG_CYC), .SECT_CYC(SECT_CYC),
    .BULK_CYC(BULK_CYC)) fsbp_sva_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CS_N(CS_N),
    .WP_N(WP_N), .DO_OE_N(DO_OE_N), .STATUS(STATUS), .ARR_OP(ARR_OP));

// ### testbench/fsbp_host.sv
module fsbp_host (
    output logic      link_clk,
    output logic      cs_n,
    output logic      di,
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        link_clk = 1'b0;
        cs_n = 1'b0;
        di = 1'b0;
        // A clean rising edge on the select clears the link counter before any frame.
        #10;
        cs_n = 1'b1;
    end
    // Sends the top n bits of d MSB first; q keeps the last eight bits seen.
    task automatic xfer(input logic [47:0] d, input int n, output logic [7:0] q);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            di = d[47 - i];
            #16 link_clk = 1'b1;
            q = {q[6:0], dout};
            #32 link_clk = 1'b0;
            #16;
        end
        cs_n = 1'b1;
        // A released line must not keep showing the last bit.
        di = ~di;
        #800;
    endtask
endmodule

// ### testbench/fsbp_tb_top.sv
`include "fsbp_map.svh"

module fsbp_tb_top
    import fsbp_pkg::*, fsbp_ref_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         wp_n = 1'b1;
    logic         link_clk, cs_n, di, dout, dout_oe_n, ex;
    logic [7:0]   st, q, v;
    logic [9:0]   sec, bnd;
    logic [3:0]   lv;
    fsbp_arr_op_s op, last_op;
    int           num_errors = 0;
    int           n_checks = 0;
    int           n_ops = 0;
    int           cyc = 0;
    int           seed = 32'ha6b9;
    int           m;

    always #50 sys_clk = ~sys_clk;

    fsbp_top #(.WRSR_CYC(24'h3), .PROG_CYC(24'h4), .SECT_CYC(24'h50), .BULK_CYC(24'h6))
    fsbp_top_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK_CLK(link_clk), .CS_N(cs_n),
        .DI(di), .WP_N(wp_n), .DO(dout), .DO_OE_N(dout_oe_n), .STATUS(st), .ARR_OP(op));
    fsbp_host fsbp_host_inst (.link_clk(link_clk), .cs_n(cs_n), .di(di), .dout(dout));

    task final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    // Sampled on the falling edge so the one-cycle pulse is read where it is settled.
    always @(negedge sys_clk) begin
        cyc++;
        if (op.valid === 1'b1) begin
            n_ops++;
            last_op = op;
        end
        if (cyc == 30000) begin
            num_errors++;
            final_report();
        end
    end

    task idle;
        for (int k = 0; k < 200 && st[0] !== 1'b0; k++) @(negedge sys_clk);
    endtask

    task cmd(input logic [47:0] d, input int n);
        fsbp_host_inst.xfer(d, n, q);
        idle();
    endtask

    task wrsr(input logic [7:0] val);
        cmd({`FSBP_OP_WREN, 40'h0}, 8);
        cmd({`FSBP_OP_WRSR, val, 32'h0}, 16);
    endtask

    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        check(st, 8'ha0);
        fsbp_host_inst.xfer({`FSBP_OP_RDSR, 40'h0}, 16, q);
        check(q, 8'ha0);
        cmd({`FSBP_OP_WRSR, 8'h00, 32'h0}, 16);
        check(st, 8'ha0);
        cmd({`FSBP_OP_WREN, 40'h0}, 8);
        check(st, 8'ha2);
        cmd({`FSBP_OP_WRSR, 8'h00, 32'h0}, 16);
        check(st, 8'h00);
        // Odd passes aim at the sector either side of the region's edge.
        for (int i = 0; i < 40; i++) begin
            v = $random(seed);
            v = {1'b0, v[6:2], 2'b00};
            lv = {v[6], v[4:2]};
            wrsr(v);
            check(st, v);
            sec = $random(seed);
            bnd = (10'h1 << (lv - 4'h1)) - {9'h0, sec[0]};
            if (i[0]) sec = v[5] ? bnd : ~bnd;
            ex = !prot(lv, v[5], sec);
            m = n_ops;
            cmd({`FSBP_OP_WREN, 40'h0}, 8);
            cmd({`FSBP_OP_PROG, 6'h0, sec, 16'h0, v}, 48);
            if (ex) check({last_op.erase, last_op.bulk, 4'h0, last_op.addr[25:16]}, sec);
            if (ex) check({8'h00, last_op.data}, {8'h00, v});
            cmd({`FSBP_OP_WREN, 40'h0}, 8);
            cmd({`FSBP_OP_BULK, 40'h0}, 8);
            check(16'(n_ops - m), 16'(ex) + 16'(lv == 4'h0));
            check(st, v);
        end
        wrsr(8'h00);
        cmd({`FSBP_OP_WREN, 40'h0}, 8);
        fsbp_host_inst.xfer({`FSBP_OP_SECT, 40'h0}, 40, q);
        fsbp_host_inst.xfer({`FSBP_OP_RDSR, 40'h0}, 16, q);
        v = q;
        fsbp_host_inst.xfer({`FSBP_OP_RDFSR, 40'h0}, 16, q);
        check({v[0], q[7]}, 2'b10);
        idle();
        fsbp_host_inst.xfer({`FSBP_OP_RDFSR, 40'h0}, 16, q);
        check({q[7], last_op.erase}, 2'b11);
        wrsr(8'h80);
        @(negedge sys_clk) wp_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        wrsr(8'h1c);
        check(st, 8'h80);
        @(negedge sys_clk) wp_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        wrsr(8'h1c);
        check(st, 8'h1c);
        @(negedge sys_clk) rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(st, 8'ha0);
        final_report();
    end
endmodule
